/* src/updown_counter_defs.vh */
/*
  Constants for the up/down counter channel: register offsets, field
  positions, mode codes and timing counts.
  Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef UPDOWN_COUNTER_DEFS_VH
`define UPDOWN_COUNTER_DEFS_VH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL     8'h00
`define OFS_LOAD     8'h04
`define OFS_END      8'h08
`define OFS_CMPV     8'h0C
`define OFS_OUTCFG   8'h10
`define OFS_COUNT    8'h14
`define OFS_LATCH    8'h18
`define OFS_STATUS   8'h1C
`define OFS_IRQEN    8'h20

// ==========================================================================
// Control register fields
`define CTRL_SWGATE  0
`define CTRL_ABORT   1
`define CTRL_PERIOD  2
`define CTRL_DIR_LO  3
`define CTRL_DIR_HI  4
`define CTRL_HWGEN   5
`define CTRL_OUTCTL  6
`define CTRL_PWM     7

// Main direction codes
`define DIR_NONE     2'h0
`define DIR_FWD      2'h1
`define DIR_BWD      2'h2

// Output mode codes (OUTCFG[1:0]), pulse duration OUTCFG[15:8], hyst [23:16]
`define OM_NONE      2'h0
`define OM_GE        2'h1
`define OM_LE        2'h2
`define OM_PULSE     2'h3

// Status bits (bits 0 to 3 write one to clear; OUTPUT and GATE are read-only)
`define ST_CMP       0
`define ST_OFLW      1
`define ST_UFLW      2
`define ST_END       3
`define ST_OUTPUT    4
`define ST_GATE      5

// Count limits
`define CNT_MAX      32'h7FFFFFFF
`define CNT_MIN      32'h80000000

// Pulse step of 2 ms at 200 MHz: 2e6 ns / 5 ns
`define STEP_NS      2000000
`define CLK_NS       5
`define STEP_CYC     (`STEP_NS / `CLK_NS)

`endif

/* src/updown_counter_compare_gate.v */
/*
  One up/down counter channel with gate logic, end-value reload,
  comparator output with pulse timer and hysteresis, and an optional
  hardware gate and latch input (counter three only).
  Assumes count pulses and direction come from pins on any timing;
  they are synchronised here. Registers sit on an AXI4-Lite slave.
*/
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "updown_counter_defs.vh"
module updown_counter_compare_gate #(
  parameter        IS_COUNTER3 = 1,
  parameter [31:0] STEP_CYCLES = `STEP_CYC
) (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_I,
  // Pins
  input  wire        COUNT_PULSE_I,
  input  wire        COUNT_DIR_I,
  input  wire        HW_GATE_I,
  input  wire        LATCH_I,
  input  wire        DIGITAL_IN_OUT_I,
  output reg         CHANNEL_OUT_O,
  output reg         IRQ_O,
  // AXI4-Lite write address
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output wire        S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output wire        S_AXI_WREADY_O,
  // AXI4-Lite write response
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  // AXI4-Lite read
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output wire        S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I
);
  // ========================================================================
  // Pin synchronisers
  reg [1:0] pulse_s;
  reg [1:0] dir_s;
  reg [1:0] hwg_s;
  reg [1:0] latch_s;
  reg       pulse_d;
  reg       hwg_d;
  reg       latch_d;
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pulse_s <= 2'h0;
      dir_s   <= 2'h0;
      hwg_s   <= 2'h0;
      latch_s <= 2'h0;
      pulse_d <= 1'b0;
      hwg_d   <= 1'b0;
      latch_d <= 1'b0;
    end else begin
      pulse_s <= {pulse_s[0], COUNT_PULSE_I};
      dir_s   <= {dir_s[0], COUNT_DIR_I};
      hwg_s   <= {hwg_s[0], HW_GATE_I};
      latch_s <= {latch_s[0], LATCH_I};
      pulse_d <= pulse_s[1];
      hwg_d   <= hwg_s[1];
      latch_d <= latch_s[1];
    end
  end
  // ========================================================================
  // Registers
  reg         [7:0]  ctrl;
  reg  signed [31:0] load_value;
  reg  signed [31:0] end_value;
  reg  signed [31:0] cmp_value;
  reg         [23:0] out_cfg;
  reg  signed [31:0] count;
  reg  signed [31:0] latched_count_value;
  reg                compare_status_bit;
  reg                overflow_status_bit;
  reg                underflow_status_bit;
  reg                end_status_bit;
  reg         [4:0]  irq_en;
  wire       sw_gate  = ctrl[`CTRL_SWGATE];
  wire       abort_md = ctrl[`CTRL_ABORT];
  wire       periodic = ctrl[`CTRL_PERIOD];
  wire [1:0] main_dir = ctrl[`CTRL_DIR_HI:`CTRL_DIR_LO];
  wire       hwg_on   = (IS_COUNTER3 != 0) && ctrl[`CTRL_HWGEN];
  wire [1:0] out_mode = out_cfg[1:0];
  // ========================================================================
  // AXI4-Lite slave: address and data taken together, one at a time
  wire       wr_go = S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_BVALID_O;
  wire       rd_go = S_AXI_ARVALID_I && !S_AXI_RVALID_O;
  assign S_AXI_AWREADY_O = wr_go;
  assign S_AXI_WREADY_O  = wr_go;
  assign S_AXI_ARREADY_O = rd_go;
  wire [7:0] wa = S_AXI_AWADDR_I;
  wire       wr_ok = (wa[1:0] == 2'h0) && (wa <= `OFS_IRQEN);
  wire       wfull = (S_AXI_WSTRB_I == 4'hF);
  wire       w_ctrl = wr_go && wfull && (wa == `OFS_CTRL);
  wire       w_stat = wr_go && wfull && (wa == `OFS_STATUS);
  // End value legality per main direction
  function end_legal;
    input [1:0]         dir;
    input signed [31:0] v;
    begin
      end_legal = !((dir == `DIR_FWD && v == `CNT_MIN) ||
                    (dir == `DIR_BWD && v == `CNT_MAX));
    end
  endfunction
  // ========================================================================
  // Gate logic
  wire sw_rise  = w_ctrl && S_AXI_WDATA_I[`CTRL_SWGATE] && !sw_gate;
  wire hwg_rise = hwg_s[1] && !hwg_d;
  wire hwg_fall = !hwg_s[1] && hwg_d;
  reg  auto_closed;
  reg  hw_armed;
  wire igate = sw_gate && (!hwg_on || hwg_s[1]) && !auto_closed;
  wire pwm_on = ctrl[`CTRL_PWM];
  wire run    = igate && !pwm_on;
  // Gate reopening decides between restart and continue
  reg  reopen;
  reg  restart;
  always @* begin
    reopen  = 1'b0;
    restart = 1'b0;
    if (!hwg_on) begin
      reopen  = sw_rise;
      restart = sw_rise && (abort_md || auto_closed);
    end else if (auto_closed) begin
      reopen  = (hwg_rise && sw_gate) || (sw_rise && hw_armed);
      restart = reopen;
    end else begin
      reopen  = (sw_rise && hwg_s[1]) || (hwg_rise && sw_gate);
      restart = hwg_rise && sw_gate && abort_md;
    end
  end
  // ========================================================================
  // Counting
  wire        cnt_evt = pulse_s[1] && !pulse_d && run;
  wire        up      = dir_s[1];
  reg  signed [31:0] next_count;
  reg         next_close;
  reg         ev_of;
  reg         ev_uf;
  reg         ev_end;
  always @* begin
    next_count = count;
    next_close = 1'b0;
    ev_of      = 1'b0;
    ev_uf      = 1'b0;
    ev_end     = 1'b0;
    if (cnt_evt) begin
      if (main_dir == `DIR_FWD && up && count == end_value - 32'sh1) begin
        next_count = load_value;
        next_close = !periodic;
        ev_end     = 1'b1;
      end else if (main_dir == `DIR_BWD && !up && count == end_value + 32'sh1) begin
        next_count = load_value;
        next_close = !periodic;
        ev_end     = 1'b1;
      end else if (up && count == `CNT_MAX) begin
        ev_of      = 1'b1;
        next_count = periodic ? load_value : `CNT_MIN;
        next_close = !periodic && main_dir == `DIR_NONE;
      end else if (!up && count == `CNT_MIN) begin
        ev_uf      = 1'b1;
        next_count = periodic ? load_value : `CNT_MAX;
        next_close = !periodic && main_dir == `DIR_NONE;
      end else begin
        next_count = up ? count + 32'sh1 : count - 32'sh1;
      end
    end
  end
  // ========================================================================
  // Comparator with hysteresis
  reg  [7:0]  hyst;
  reg         hyst_lock;
  reg  signed [31:0] hyst_ref;
  wire signed [31:0] hyst_w = {24'h0, hyst};
  wire        hyst_act = (hyst > 8'h01);
  wire        raw_ge = count >= cmp_value;
  wire        raw_le = count <= cmp_value;
  wire        raw_eq = count == cmp_value;
  wire        away = (count >= hyst_ref + hyst_w) || (count <= hyst_ref - hyst_w);
  reg         cond;
  always @* begin
    case (out_mode)
      `OM_GE:    cond = raw_ge;
      `OM_LE:    cond = raw_le;
      `OM_PULSE: cond = raw_eq;
      default:   cond = 1'b0;
    endcase
  end
  wire cond_f = hyst_lock ? cond || !away : cond;
  reg  prev_cond;
  reg  cnt_evt_d;
  wire from_main = (main_dir == `DIR_NONE) ||
                   (main_dir == `DIR_FWD && up) || (main_dir == `DIR_BWD && !up);
  wire cmp_hit = cond_f && !prev_cond && cnt_evt_d && from_main;
  reg  [7:0]  pulse_len;
  reg  [7:0]  pulse_steps;
  reg  [31:0] step_cnt;
  reg         pulse_on;
  reg         output_state_bit;
  // ========================================================================
  // Main sequential process
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ctrl <= 8'h00;
      load_value <= 32'h00000000;
      end_value <= `CNT_MAX;
      cmp_value <= 32'h00000000;
      out_cfg <= 24'h000000;
      count <= 32'h00000000;
      latched_count_value <= 32'h00000000;
      compare_status_bit <= 1'b0;
      overflow_status_bit <= 1'b0;
      underflow_status_bit <= 1'b0;
      end_status_bit <= 1'b0;
      irq_en <= 5'h00;
      auto_closed <= 1'b0;
      hw_armed <= 1'b0;
      hyst <= 8'h00;
      hyst_lock <= 1'b0;
      hyst_ref <= 32'h00000000;
      prev_cond <= 1'b0;
      cnt_evt_d <= 1'b0;
      pulse_len <= 8'h00;
      pulse_steps <= 8'h00;
      step_cnt <= 32'h00000000;
      pulse_on <= 1'b0;
      output_state_bit <= 1'b0;
      IRQ_O <= 1'b0;
      CHANNEL_OUT_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'h0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O <= 2'h0;
      S_AXI_RDATA_O <= 32'h00000000;
    end else begin
      cnt_evt_d <= cnt_evt;
      // Register writes
      if (wr_go) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= (wr_ok && wfull) ? 2'h0 : 2'h2;
        if (wfull) begin
          case (wa)
            `OFS_CTRL:   ctrl <= S_AXI_WDATA_I[7:0];
            `OFS_LOAD:   load_value <= S_AXI_WDATA_I;
            `OFS_END:    if (end_legal(main_dir, S_AXI_WDATA_I))
                           end_value <= S_AXI_WDATA_I;
            `OFS_CMPV:   cmp_value <= S_AXI_WDATA_I;
            `OFS_OUTCFG: out_cfg <= S_AXI_WDATA_I[23:0];
            `OFS_IRQEN:  irq_en <= S_AXI_WDATA_I[4:0];
            default:     ;
          endcase
        end
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      // Register reads
      if (rd_go) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= 2'h0;
        case (S_AXI_ARADDR_I)
          `OFS_CTRL:   S_AXI_RDATA_O <= {24'h0, ctrl};
          `OFS_LOAD:   S_AXI_RDATA_O <= load_value;
          `OFS_END:    S_AXI_RDATA_O <= end_value;
          `OFS_CMPV:   S_AXI_RDATA_O <= cmp_value;
          `OFS_OUTCFG: S_AXI_RDATA_O <= {8'h0, out_cfg};
          `OFS_COUNT:  S_AXI_RDATA_O <= count;
          `OFS_LATCH:  S_AXI_RDATA_O <= latched_count_value;
          `OFS_STATUS: S_AXI_RDATA_O <= {26'h0, igate, output_state_bit, end_status_bit,
                                         underflow_status_bit, overflow_status_bit,
                                         compare_status_bit};
          `OFS_IRQEN:  S_AXI_RDATA_O <= {27'h0, irq_en};
          default: begin
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= 2'h2;
          end
        endcase
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
      // Count, reload and automatic gate close
      if (reopen && restart)
        count <= load_value;
      else
        count <= next_count;
      if (next_close)
        auto_closed <= 1'b1;
      else if (reopen)
        auto_closed <= 1'b0;
      if (!auto_closed || !hwg_on)
        hw_armed <= 1'b0;
      else if (hwg_rise)
        hw_armed <= 1'b1;
      if (latch_s[1] && !latch_d && run && IS_COUNTER3 != 0)
        latched_count_value <= count;
      // Hysteresis band, new width taken on every cycle the band is unlocked
      prev_cond <= cond_f;
      if (cond && !prev_cond && hyst_act && !hyst_lock) begin
        hyst_lock <= 1'b1;
        hyst_ref  <= count;
      end else if (hyst_lock && away) begin
        hyst_lock <= 1'b0;
      end
      if (!hyst_lock)
        hyst <= out_cfg[23:16];

      // Pulse timer
      if (pulse_on) begin
        if (step_cnt == STEP_CYCLES - 32'h1) begin
          step_cnt <= 32'h00000000;
          pulse_steps <= pulse_steps + 8'h01;
          if (pulse_steps + 8'h01 >= pulse_len)
            pulse_on <= 1'b0;
        end else begin
          step_cnt <= step_cnt + 32'h1;
        end
      end else if (out_mode == `OM_PULSE && cmp_hit && ctrl[`CTRL_OUTCTL]
                   && out_cfg[15:8] != 8'h00) begin
        pulse_on <= 1'b1;
        pulse_len <= out_cfg[15:8];
        pulse_steps <= 8'h00;
        step_cnt <= 32'h00000000;
      end
      // Output pin
      case (out_mode)
        `OM_NONE:  output_state_bit <= 1'b0;
        `OM_PULSE: output_state_bit <= ctrl[`CTRL_OUTCTL] &&
                     ((out_cfg[15:8] == 8'h00) ? cond_f : pulse_on);
        default:   output_state_bit <= ctrl[`CTRL_OUTCTL] && cond_f;
      endcase
      CHANNEL_OUT_O <= (out_mode == `OM_NONE) ? DIGITAL_IN_OUT_I : output_state_bit;
      // Status bits: set wins over clear
      if (out_mode == `OM_NONE)
        compare_status_bit <= 1'b0;
      else if (cond_f && (out_mode != `OM_PULSE || cmp_hit))
        compare_status_bit <= 1'b1;
      else if (w_stat && S_AXI_WDATA_I[`ST_CMP] && !cond_f && !pulse_on)
        compare_status_bit <= 1'b0;
      if (ev_of)
        overflow_status_bit <= 1'b1;
      else if (w_stat && S_AXI_WDATA_I[`ST_OFLW])
        overflow_status_bit <= 1'b0;
      if (ev_uf)
        underflow_status_bit <= 1'b1;
      else if (w_stat && S_AXI_WDATA_I[`ST_UFLW])
        underflow_status_bit <= 1'b0;
      if (ev_end)
        end_status_bit <= 1'b1;
      else if (w_stat && S_AXI_WDATA_I[`ST_END])
        end_status_bit <= 1'b0;

      // One-cycle interrupt pulse
      IRQ_O <= (irq_en[0] && cmp_hit && out_mode != `OM_NONE) ||
               (irq_en[1] && (ev_of || (ev_end && up))) ||
               (irq_en[2] && (ev_uf || (ev_end && !up))) ||
               (IS_COUNTER3 == 0 && sw_gate && irq_en[3] && hwg_rise) ||
               (IS_COUNTER3 == 0 && sw_gate && irq_en[4] && hwg_fall);
    end
  end

endmodule

/* tb/updown_counter_compare_gate_sva.sv */
/*
  Checker for the counter channel: bus answers, refusals, plain output, interrupt pulse.
  Assumes only the top ports are visible; bound to the design below.
*/
`timescale 1ns/10ps
module updown_counter_compare_gate_sva (
  // Clock, reset and pins
  input wire        CORE_CLK_I,
  input wire        RST_I,
  input wire        DIGITAL_IN_OUT_I,
  input wire        CHANNEL_OUT_O,
  input wire        IRQ_O,
  // Write channels
  input wire [7:0]  S_AXI_AWADDR_I,
  input wire        S_AXI_AWVALID_I,
  input wire        S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0]  S_AXI_WSTRB_I,
  input wire        S_AXI_WVALID_I,
  input wire        S_AXI_WREADY_O,
  input wire [1:0]  S_AXI_BRESP_O,
  input wire        S_AXI_BVALID_O,
  input wire        S_AXI_BREADY_I,
  // Read channels
  input wire [7:0]  S_AXI_ARADDR_I,
  input wire        S_AXI_ARVALID_I,
  input wire        S_AXI_ARREADY_O,
  input wire [31:0] S_AXI_RDATA_O,
  input wire [1:0]  S_AXI_RRESP_O,
  input wire        S_AXI_RVALID_O,
  input wire        S_AXI_RREADY_I
);
  // ==========
  // Output mode tracked from taken writes
  wire      wr = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire      rd = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  reg [1:0] om;
  reg [1:0] om_d;
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      om   <= 2'h0;
      om_d <= 2'h0;
    end else begin
      if (wr && S_AXI_AWADDR_I == 8'h10 && S_AXI_WSTRB_I == 4'hF) begin
        om <= S_AXI_WDATA_I[1:0];
      end
      om_d <= om;
    end
  end
  // ==========
  // Properties
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_wr_answer: assert property (wr |=> S_AXI_BVALID_O)
    else $error("write response late");
  a_wr_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  a_wr_busy: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while busy");
  a_wr_strobe: assert property (wr && S_AXI_WSTRB_I != 4'hF |=> S_AXI_BRESP_O == 2'h2)
    else $error("partial write accepted");
  a_rd_answer: assert property (rd && !S_AXI_RVALID_O |=> S_AXI_RVALID_O)
    else $error("read response late");
  a_rd_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read response dropped");
  a_rd_unmapped: assert property (rd && S_AXI_ARADDR_I > 8'h20 |=>
    S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0) else $error("unmapped read");
  a_irq_single: assert property (IRQ_O |=> !IRQ_O)
    else $error("interrupt longer than one cycle");
  a_plain_out: assert property (om == 2'h0 && om_d == 2'h0 && !$past(RST_I) |->
    CHANNEL_OUT_O == $past(DIGITAL_IN_OUT_I)) else $error("plain output wrong");
  c_refused: cover property (wr && S_AXI_WSTRB_I != 4'hF);
  c_unmapped: cover property (rd && S_AXI_ARADDR_I > 8'h20);
  c_irq: cover property (IRQ_O);
endmodule

bind updown_counter_compare_gate updown_counter_compare_gate_sva chk_inst (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .DIGITAL_IN_OUT_I(DIGITAL_IN_OUT_I),
  .CHANNEL_OUT_O(CHANNEL_OUT_O), .IRQ_O(IRQ_O), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I)
);

/* tb/pulse_source.sv */
/*
  Pin source for the counter: count pulses with direction, and the gate level.
  Assumes calls right after a clock edge; each level lasts at least 4 clocks for the synchroniser.
*/
`timescale 1ns/10ps
module pulse_source (
  // Clock
  input  wire clk_i,
  // Pins
  output reg  pulse_o,
  output reg  dir_o,
  output reg  gate_o
);
  initial begin
    pulse_o = 1'b0;
    dir_o   = 1'b1;
    gate_o  = 1'b0;
  end
  // ==========
  // One count pulse
  task pulse(input up);
    begin
      dir_o <= up;
      repeat (4) @(posedge clk_i);
      pulse_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      pulse_o <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
  // ==========
  // Gate level, settled on return
  task gate(input v);
    begin
      gate_o <= v;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule

/* tb/updown_counter_compare_gate_tb.sv */
/*
  Bench for the counter channel: bus tasks, a count model, scenarios.
  Assumes the pin source model and the bound checker.
*/
`timescale 1ns/10ps
`include "updown_counter_defs.vh"
module updown_counter_compare_gate_tb;
  localparam [31:0] STEP = 32'hA;
  localparam integer MAXI = 32'h7FFFFFFF;
  localparam integer MINI = 32'h80000000;
  reg         clk;
  reg         rst;
  reg         din;
  reg         lat;
  reg  [7:0]  awaddr;
  reg         awvalid;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg         wvalid;
  reg         bready;
  reg  [7:0]  araddr;
  reg         arvalid;
  reg         rready;
  wire        awready;
  wire        wready;
  wire [1:0]  bresp;
  wire        bvalid;
  wire        arready;
  wire [31:0] rdata;
  wire [1:0]  rresp;
  wire        rvalid;
  wire        out;
  wire        irq;
  wire        pls;
  wire        dir;
  wire        gt;
  reg  [31:0] rv;
  reg  [31:0] e;
  reg  [1:0]  resp;
  reg  [1:0]  m_dir;
  reg         m_per;
  reg         m_gate;
  reg         up;
  integer     m_cnt;
  integer     m_load;
  integer     m_irq;
  integer     seed;
  integer     mismatches;
  integer     compares;
  integer     cycles;
  integer     irq_n;
  integer     hi_n;
  integer     i;
  integer     j;

  updown_counter_compare_gate #(
    .IS_COUNTER3 (1),
    .STEP_CYCLES (STEP)
  ) updown_counter_compare_gate_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .COUNT_PULSE_I(pls), .COUNT_DIR_I(dir),
    .HW_GATE_I(gt), .LATCH_I(lat), .DIGITAL_IN_OUT_I(din), .CHANNEL_OUT_O(out),
    .IRQ_O(irq), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
  );
  pulse_source pulse_source_inst (
    .clk_i   (clk),
    .pulse_o (pls),
    .dir_o   (dir),
    .gate_o  (gt)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========
  // Cycle count, watchdog, pin monitors
  always @(posedge clk) begin
    cycles = cycles + 1;
    din <= cycles[2];
    if (irq === 1'b1) irq_n = irq_n + 1;
    if (out === 1'b1) hi_n = hi_n + 1;
    if (cycles == 50000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  task give_verdict;
    begin
      if (mismatches == 0 && compares > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  task chk(input [8*6:1] nm, input [31:0] x, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask

  // ==========
  // Bus master
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
    end
  endtask

  task wrk(input [7:0] a, input [31:0] d);
    wr(a, d, 4'hF);
  endtask

  task rd(input [7:0] a);
    begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
    end
  endtask

  // ==========
  // Count model
  task step(input u);
    begin
      pulse_source_inst.pulse(u);
      if (m_gate) begin
        if (m_dir == `DIR_FWD && u && m_cnt == e - 1 ||
            m_dir == `DIR_BWD && !u && m_cnt == e + 1 ||
            m_dir == `DIR_NONE && m_per && m_cnt == (u ? MAXI : MINI)) begin
          m_cnt = m_load;
          if (m_per) m_irq = m_irq + 1;
          if (!m_per) m_gate = 1'b0;
        end else begin
          m_cnt = u ? m_cnt + 1 : m_cnt - 1;
        end
      end
      rd(`OFS_COUNT);
      chk("count", m_cnt, rv);
    end
  endtask

  task cfg(input per, input [1:0] d, input [31:0] ld, input [31:0] ev);
    begin
      wrk(`OFS_CTRL, {27'h0, d, per, 2'h2});
      wrk(`OFS_LOAD, ld);
      wrk(`OFS_END, ev);
      wrk(`OFS_IRQEN, per ? 32'h6 : 32'h0);
      wrk(`OFS_CTRL, {27'h0, d, per, 2'h3});
      m_dir = d;
      m_per = per;
      m_load = ld;
      e = ev;
      m_cnt = ld;
      m_gate = 1'b1;
    end
  endtask

  // Latch pin pulse, then the latched word against the expectation
  task latch_chk(input [31:0] x);
    begin
      lat <= 1'b1;
      repeat (4) @(posedge clk);
      lat <= 1'b0;
      rd(`OFS_LATCH);
      chk("latch", x, rv);
    end
  endtask

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F ^ 6'h1F;
    {lat, din, awaddr, wdata, wstrb, araddr} = 54'h0;
    {mismatches, compares, cycles, irq_n, hi_n, m_irq} = 192'h0;
    seed = 91094;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_END);
    chk("end", `CNT_MAX, rv);
    rd(8'h24);
    chk("rresp", 2'h2, resp);
    wr(`OFS_LOAD, 32'h5, 4'h1);
    chk("bresp", 2'h2, resp);
    for (i = 0; i < 4; i = i + 1) begin
      e = i < 2 ? 32'h80000000 + i : 32'h7FFFFFFF - (i - 2);
      wrk(`OFS_CTRL, i < 2 ? 32'h8 : 32'h10);
      wrk(`OFS_END, 32'h1);
      wrk(`OFS_END, e);
      rd(`OFS_END);
      chk("end", i % 2 ? e : 32'h1, rv);
    end
    for (j = 0; j < 5; j = j + 1) begin
      cfg(j % 2 || j == 4, j < 2 ? `DIR_FWD : j < 4 ? `DIR_BWD : `DIR_NONE,
          j == 4 ? 32'h7FFFFFFE : 32'h0, j < 2 ? 32'h2 : j < 4 ? 32'hFFFFFFFE : `CNT_MAX);
      for (i = 0; i < 12; i = i + 1) begin
        up = m_per ? (($random(seed) & 3) != 0) ^ (m_dir == `DIR_BWD) : m_dir != `DIR_BWD;
        step(up);
      end
      rd(`OFS_STATUS);
      chk("gate", m_gate, rv[5]);
      chk("irq", m_irq, irq_n);
      wrk(`OFS_CTRL, {27'h0, m_dir, m_per, 2'h2});
      wrk(`OFS_CTRL, {27'h0, m_dir, m_per, 2'h3});
      m_cnt = m_load;
      m_gate = 1'b1;
      step(m_dir != `DIR_BWD);
    end
    rd(`OFS_STATUS);
    chk("cmpst", 32'h0, rv & 32'h11);
    wrk(`OFS_CTRL, 32'h4);
    m_gate = 1'b0;
    step(1'b1);
    latch_chk(32'h0);
    wrk(`OFS_CTRL, 32'h5);
    m_gate = 1'b1;
    step(1'b1);
    wrk(`OFS_CTRL, 32'h27);
    m_gate = 1'b0;
    step(1'b1);
    pulse_source_inst.gate(1'b1);
    m_cnt = m_load;
    m_gate = 1'b1;
    step(1'b1);
    pulse_source_inst.gate(1'b0);
    m_gate = 1'b0;
    step(1'b1);
    wrk(`OFS_CTRL, 32'h26);
    pulse_source_inst.gate(1'b1);
    wrk(`OFS_CTRL, 32'h27);
    m_gate = 1'b1;
    step(1'b1);
    wrk(`OFS_CTRL, 32'h07);
    pulse_source_inst.gate(1'b0);
    step(1'b1);
    latch_chk(m_cnt);
    cfg(1'b1, `DIR_NONE, 32'd100, `CNT_MAX);
    wrk(`OFS_CMPV, 32'd101);
    wrk(`OFS_OUTCFG, 32'h0403);
    wrk(`OFS_CTRL, 32'h45);
    @(negedge clk);
    hi_n = 0;
    @(posedge clk);
    step(1'b1);
    step(1'b0);
    step(1'b1);
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk("pulse", 32'h1, hi_n >= 4 * STEP - STEP / 2 && hi_n <= 4 * STEP + STEP / 2);
    @(posedge clk);
    wrk(`OFS_OUTCFG, 32'h1);
    wrk(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS);
    chk("cmpst", 32'h11, rv & 32'h11);
    step(1'b0);
    wrk(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS);
    chk("cmpst", 32'h0, rv & 32'h11);
    wrk(`OFS_CTRL, 32'hC5);
    m_gate = 1'b0;
    step(1'b1);
    give_verdict;
  end
endmodule
